// ==== design/ldhs_fsm.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module ldhs_fsm
	import ldhs_pkg::*;
#(
	parameter int TIMER_CYCLES = SIGNAL_HOLD_CYCLES,
	parameter logic [CODE_W-1:0] LS_NONE = LS_NONE_DEF,
	parameter logic [CODE_W-1:0] LS_CANNOT_RECEIVE = LS_CANNOT_RECEIVE_DEF,
	parameter logic [CODE_W-1:0] LS_WANT_TO_RECEIVE = LS_WANT_TO_RECEIVE_DEF,
	parameter logic [CODE_W-1:0] DS_NONE = DS_NONE_DEF,
	parameter logic [CODE_W-1:0] DS_WANT_TO_TRANSFER = DS_WANT_TO_TRANSFER_DEF,
	parameter logic [CODE_W-1:0] DS_READY_TO_RECEIVE = DS_READY_TO_RECEIVE_DEF,
	parameter logic [CODE_W-1:0] DC_GET_READY = DC_GET_READY_DEF,
	parameter logic [CODE_W-1:0] DC_START_TRANSFER = DC_START_TRANSFER_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic full_down,
	input wire logic door_closed,
	input wire logic door_open,
	input wire logic full_up,
	input wire logic seq_disch_allowed,
	input wire logic wash_done,
	input wire logic disch_done,
	input wire logic [CODE_W-1:0] disch_cmd,
	output logic door_close,
	output logic seq_load_done,
	output logic wash_run,
	output logic seq_disch_desired,
	output logic shuttle_disch_allowed,
	output logic allied_disch_desired,
	output logic shuttle_flag_down,
	output logic lu_allowed,
	output logic disch_commanded,
	output logic start_discharging,
	output logic disch_run,
	output logic [CODE_W-1:0] load_status,
	output logic [CODE_W-1:0] disch_status
);
	localparam int IN_BITS = 7;
	localparam int SYNC_W = IN_BITS + CODE_W;

	typedef struct packed {
		ldhs_state_t state;
		logic tmr_start;
		logic door_close;
		logic seq_load_done;
		logic wash_run;
		logic seq_disch_desired;
		logic shuttle_disch_allowed;
		logic allied_disch_desired;
		logic shuttle_flag_down;
		logic lu_allowed;
		logic disch_commanded;
		logic start_discharging;
		logic disch_run;
		logic [CODE_W-1:0] load_status;
		logic [CODE_W-1:0] disch_status;
		logic ctrl_enable;
		logic start_req;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ldhs_fsm_t;

	ldhs_fsm_t s_reg;
	ldhs_fsm_t s_next;
	logic [SYNC_W-1:0] pins_sync;
	logic in_full_down;
	logic in_door_closed;
	logic in_door_open;
	logic in_full_up;
	logic in_seq_allowed;
	logic in_wash_done;
	logic in_disch_done;
	logic [CODE_W-1:0] in_cmd;
	logic [31:0] status_word;
	logic [31:0] codes_word;
	logic write_start;

	ldhs_tmr_if tmr_bus ();

	if (TIMER_CYCLES < 2) begin : g_chk
		$error("ldhs_fsm: TIMER_CYCLES must be at least 2.");
	end

	//////////////////////////////////////////////////////////////////////////
	// Every outside level passes two flops; the command code is assumed to
	// be held stable by the supervisor for several cycles, so bits skew once.
	ldhs_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({disch_cmd, disch_done, wash_done, seq_disch_allowed,
			full_up, door_open, door_closed, full_down}),
		.sync_out(pins_sync)
	);

	assign in_full_down = pins_sync[0];
	assign in_door_closed = pins_sync[1];
	assign in_door_open = pins_sync[2];
	assign in_full_up = pins_sync[3];
	assign in_seq_allowed = pins_sync[4];
	assign in_wash_done = pins_sync[5];
	assign in_disch_done = pins_sync[6];
	assign in_cmd = pins_sync[SYNC_W-1:IN_BITS];

	ldhs_timer #(
		.CYCLES(TIMER_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.port(tmr_bus.tmr)
	);

	assign tmr_bus.start = s_reg.tmr_start;

	//////////////////////////////////////////////////////////////////////////
	// Readback words.
	always_comb begin
		status_word = '0;
		status_word[STATUS_STATE_LSB +: 4] = 4'(s_reg.state);
		status_word[STATUS_IN_LSB +: IN_BITS] = pins_sync[IN_BITS-1:0];
		status_word[STATUS_BUSY_BIT] = tmr_bus.busy;
		status_word[STATUS_START_BIT] = s_reg.start_req;
		codes_word = '0;
		codes_word[CODES_LOAD_LSB +: CODE_W] = s_reg.load_status;
		codes_word[CODES_DISCH_LSB +: CODE_W] = s_reg.disch_status;
		codes_word[CODES_CMD_LSB +: CODE_W] = in_cmd;
	end

	assign write_start = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid
		&& s_reg.aw_addr == CTRL_OFS && s_reg.wstrb[0]
		&& s_reg.wdata[CTRL_START_BIT];

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next = s_reg;
		s_next.tmr_start = 1'b0;

		// Write address and data are taken in either order.
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = s_axi_awaddr[ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_have = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			case (s_reg.aw_addr)
				CTRL_OFS: begin
					if (s_reg.wstrb[0]) begin
						s_next.ctrl_enable = s_reg.wdata[CTRL_ENABLE_BIT];
					end
				end
				STATUS_OFS, CODES_OFS: begin
					s_next.bresp = RESP_OKAY;
				end
				default: begin
					s_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
		end

		// Reads answer one cycle after the address is taken.
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			case (s_axi_araddr[ADDR_W-1:0])
				CTRL_OFS: begin
					s_next.rdata = 32'(s_reg.ctrl_enable);
				end
				STATUS_OFS: begin
					s_next.rdata = status_word;
				end
				CODES_OFS: begin
					s_next.rdata = codes_word;
				end
				default: begin
					s_next.rdata = '0;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end

		// Each wait state below changes outputs only on its exit.
		case (s_reg.state)
			ST_IDLE: begin
				if (s_reg.ctrl_enable && s_reg.start_req) begin
					s_next.start_req = 1'b0;
					s_next.state = ST_CLOSE_DOOR;
					s_next.load_status = LS_CANNOT_RECEIVE;
					s_next.door_close = 1'b1;
				end
			end
			ST_CLOSE_DOOR: begin
				if (in_full_down && in_door_closed) begin
					s_next.door_close = 1'b0;
					s_next.seq_load_done = 1'b1;
					s_next.tmr_start = 1'b1;
					s_next.state = ST_END_SIGNAL;
				end
			end
			ST_END_SIGNAL: begin
				// The timer raises busy one cycle after start, so start
				// itself must also be low before expiry is believed.
				if (!s_reg.tmr_start && !tmr_bus.busy) begin
					s_next.seq_load_done = 1'b0;
					s_next.wash_run = 1'b1;
					s_next.state = ST_WASH;
				end
			end
			ST_WASH: begin
				if (in_wash_done) begin
					s_next.wash_run = 1'b0;
					s_next.seq_disch_desired = 1'b1;
					s_next.state = ST_ASK_DISCHARGE;
				end
			end
			ST_ASK_DISCHARGE: begin
				if (in_seq_allowed) begin
					s_next.disch_status = DS_WANT_TO_TRANSFER;
					s_next.shuttle_disch_allowed = 1'b1;
					s_next.allied_disch_desired = 1'b1;
					s_next.state = ST_FLAG_SHUTTLE;
				end
			end
			ST_FLAG_SHUTTLE: begin
				if (in_cmd == DC_GET_READY) begin
					s_next.seq_disch_desired = 1'b0;
					s_next.shuttle_disch_allowed = 1'b0;
					s_next.shuttle_flag_down = 1'b1;
					s_next.lu_allowed = 1'b1;
					s_next.disch_commanded = 1'b1;
					s_next.state = ST_OPEN_DOOR;
				end
			end
			ST_OPEN_DOOR: begin
				if (in_door_open) begin
					s_next.lu_allowed = 1'b0;
					s_next.disch_commanded = 1'b0;
					s_next.disch_status = DS_READY_TO_RECEIVE;
					s_next.state = ST_WAIT_START;
				end
			end
			ST_WAIT_START: begin
				if (in_cmd == DC_START_TRANSFER) begin
					s_next.lu_allowed = 1'b1;
					s_next.disch_commanded = 1'b1;
					s_next.start_discharging = 1'b1;
					s_next.state = ST_TILT_FORWARD;
				end
			end
			ST_TILT_FORWARD: begin
				if (in_full_up) begin
					s_next.load_status = LS_WANT_TO_RECEIVE;
					s_next.disch_run = 1'b1;
					s_next.state = ST_DISCHARGE;
				end
			end
			ST_DISCHARGE: begin
				// Completion of discharge is owned by the next stage; here
				// the block only releases its own outputs when told.
				if (in_disch_done) begin
					s_next.disch_run = 1'b0;
					s_next.allied_disch_desired = 1'b0;
					s_next.shuttle_flag_down = 1'b0;
					s_next.lu_allowed = 1'b0;
					s_next.disch_commanded = 1'b0;
					s_next.start_discharging = 1'b0;
					s_next.disch_status = DS_NONE;
					s_next.load_status = LS_NONE;
					s_next.state = ST_IDLE;
				end
			end
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase

		// A new start write wins over the consumption in the same cycle.
		if (write_start) begin
			s_next.start_req = 1'b1;
		end

		s_next.awready = !s_next.aw_have && !s_next.bvalid;
		s_next.wready = !s_next.w_have && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.state <= ST_IDLE;
			s_reg.ctrl_enable <= CTRL_ENABLE_RST;
			s_reg.load_status <= LS_NONE;
			s_reg.disch_status <= DS_NONE;
		end else begin
			s_reg <= s_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign door_close = s_reg.door_close;
	assign seq_load_done = s_reg.seq_load_done;
	assign wash_run = s_reg.wash_run;
	assign seq_disch_desired = s_reg.seq_disch_desired;
	assign shuttle_disch_allowed = s_reg.shuttle_disch_allowed;
	assign allied_disch_desired = s_reg.allied_disch_desired;
	assign shuttle_flag_down = s_reg.shuttle_flag_down;
	assign lu_allowed = s_reg.lu_allowed;
	assign disch_commanded = s_reg.disch_commanded;
	assign start_discharging = s_reg.start_discharging;
	assign disch_run = s_reg.disch_run;
	assign load_status = s_reg.load_status;
	assign disch_status = s_reg.disch_status;
endmodule

// ==== design/ldhs_pkg.sv ====
package ldhs_pkg;

	// Status and command code width toward the supervisory controller.
	localparam int CODE_W = 2;

	// Default encodings; the top module turns each into a parameter.
	localparam logic [1:0] LS_NONE_DEF = 2'h0;
	localparam logic [1:0] LS_CANNOT_RECEIVE_DEF = 2'h1;
	localparam logic [1:0] LS_WANT_TO_RECEIVE_DEF = 2'h2;
	localparam logic [1:0] DS_NONE_DEF = 2'h0;
	localparam logic [1:0] DS_WANT_TO_TRANSFER_DEF = 2'h1;
	localparam logic [1:0] DS_READY_TO_RECEIVE_DEF = 2'h2;
	localparam logic [1:0] DC_GET_READY_DEF = 2'h1;
	localparam logic [1:0] DC_START_TRANSFER_DEF = 2'h2;

	// Timing: clock rate and the end-signal hold time.
	localparam int CLK_KHZ = 25000;
	localparam int SIGNAL_HOLD_MS = 2000;
	localparam int SIGNAL_HOLD_CYCLES = SIGNAL_HOLD_MS * CLK_KHZ;
	localparam int TIMER_W = 32;

	// Register byte offsets.
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] CODES_OFS = 4'h8;
	localparam int ADDR_W = 4;

	// Control register fields and reset value.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam logic CTRL_ENABLE_RST = 1'b0;

	// Status register fields.
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_IN_LSB = 4;
	localparam int STATUS_BUSY_BIT = 12;
	localparam int STATUS_START_BIT = 13;

	// Codes register fields.
	localparam int CODES_LOAD_LSB = 0;
	localparam int CODES_DISCH_LSB = 8;
	localparam int CODES_CMD_LSB = 16;

	// Response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CLOSE_DOOR,
		ST_END_SIGNAL,
		ST_WASH,
		ST_ASK_DISCHARGE,
		ST_FLAG_SHUTTLE,
		ST_OPEN_DOOR,
		ST_WAIT_START,
		ST_TILT_FORWARD,
		ST_DISCHARGE
	} ldhs_state_t;

endpackage

// ==== design/ldhs_tmr_if.sv ====
`timescale 1ns/100ps
interface ldhs_tmr_if;
	logic start;
	logic busy;
	modport ctl (output start, input busy);
	modport tmr (input start, output busy);
endinterface

// ==== design/ldhs_sync.sv ====
`timescale 1ns/100ps
module ldhs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} ldhs_sync_t;

	ldhs_sync_t s_reg;
	ldhs_sync_t s_next;

	if (WIDTH < 1) begin : g_chk
		$error("ldhs_sync: WIDTH must be at least 1.");
	end

	// The first stage feeds only the second stage.
	always_comb begin
		s_next.stage1 = async_in;
		s_next.stage2 = s_reg.stage1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.stage2;
endmodule

// ==== design/ldhs_timer.sv ====
`timescale 1ns/100ps
module ldhs_timer #(
	parameter int CYCLES = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	ldhs_tmr_if.tmr port
);
	import ldhs_pkg::*;

	typedef struct packed {
		logic busy;
		logic [TIMER_W-1:0] count;
	} ldhs_timer_t;

	ldhs_timer_t s_reg;
	ldhs_timer_t s_next;

	if (CYCLES < 2) begin : g_chk
		$error("ldhs_timer: CYCLES must be at least 2.");
	end

	// A start while busy restarts the full interval.
	always_comb begin
		s_next = s_reg;
		if (port.start) begin
			s_next.busy = 1'b1;
			s_next.count = TIMER_W'(CYCLES - 1);
		end else if (s_reg.busy) begin
			if (s_reg.count == '0) begin
				s_next.busy = 1'b0;
			end else begin
				s_next.count = s_reg.count - 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign port.busy = s_reg.busy;
endmodule

// ==== testbench/ldhs_fsm_assertions.sv ====
`timescale 1ns/100ps
module ldhs_fsm_assertions
	import ldhs_pkg::*;
#(
	parameter int TIMER_CYCLES = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CODE_W-1:0] disch_cmd,
	input wire logic door_close,
	input wire logic seq_load_done,
	input wire logic wash_run,
	input wire logic seq_disch_desired,
	input wire logic shuttle_disch_allowed,
	input wire logic allied_disch_desired,
	input wire logic shuttle_flag_down,
	input wire logic lu_allowed,
	input wire logic disch_commanded,
	input wire logic start_discharging,
	input wire logic disch_run,
	input wire logic [CODE_W-1:0] load_status,
	input wire logic [CODE_W-1:0] disch_status
);
	// Counts the cycles the loading-complete signal has stood.
	logic [31:0] hold_cnt_reg;
	always_ff @(posedge aclk) begin
		hold_cnt_reg <= (!aresetn || !seq_load_done) ? 32'h0 : hold_cnt_reg + 1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_door_cmd;
		lu_allowed && disch_commanded;
	endsequence
	sequence s_ready;
		disch_status == DS_READY_TO_RECEIVE_DEF && !disch_commanded;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_close_status: assert property (
		door_close |-> load_status == LS_CANNOT_RECEIVE_DEF)
		else $error("close without status");
	a_done_follows: assert property ($fell(door_close) |-> seq_load_done)
		else $error("load done missing");
	a_hold_length: assert property (
		$fell(seq_load_done) |-> hold_cnt_reg >= TIMER_CYCLES)
		else $error("load done too short");
	a_wash_after: assert property ($rose(wash_run) |-> $fell(seq_load_done))
		else $error("wash start wrong");
	a_permit_out: assert property (
		$rose(shuttle_disch_allowed) |-> $past(seq_disch_desired) &&
		allied_disch_desired && disch_status == DS_WANT_TO_TRANSFER_DEF)
		else $error("permission outputs wrong");
	a_flag_down: assert property (
		$rose(shuttle_flag_down) |-> !seq_disch_desired ##0 s_door_cmd)
		else $error("flag down outputs wrong");
	a_door_open: assert property (
		$fell(lu_allowed) && shuttle_flag_down |-> s_ready)
		else $error("door open outputs wrong");
	a_tilt_cmd: assert property (
		$rose(start_discharging) |-> disch_cmd == DC_START_TRANSFER_DEF &&
		$past(disch_status) == DS_READY_TO_RECEIVE_DEF ##0 s_door_cmd)
		else $error("tilt without start transfer");
	a_discharge: assert property (
		$rose(disch_run) |-> $past(start_discharging) &&
		load_status == LS_WANT_TO_RECEIVE_DEF)
		else $error("discharge start wrong");
endmodule
bind ldhs_fsm ldhs_fsm_assertions #(.TIMER_CYCLES(TIMER_CYCLES)) u_chk (
	.aclk, .aresetn, .disch_cmd, .door_close, .seq_load_done, .wash_run,
	.seq_disch_desired, .shuttle_disch_allowed, .allied_disch_desired,
	.shuttle_flag_down, .lu_allowed, .disch_commanded, .start_discharging,
	.disch_run, .load_status, .disch_status);

// ==== testbench/ldhs_partner.sv ====
`timescale 1ns/100ps
module ldhs_partner
	import ldhs_pkg::*;
#(
	parameter int D = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic door_close,
	input wire logic wash_run,
	input wire logic seq_disch_desired,
	input wire logic lu_allowed,
	input wire logic disch_commanded,
	input wire logic start_discharging,
	input wire logic disch_run,
	input wire logic [CODE_W-1:0] disch_status,
	output logic full_down,
	output logic door_closed,
	output logic door_open,
	output logic full_up,
	output logic seq_disch_allowed,
	output logic wash_done,
	output logic disch_done,
	output logic [CODE_W-1:0] disch_cmd
);
	// Answers only every D+1 cycles, so each wait sees a slow far side.
	int tick = 0;
	always @(posedge aclk) begin
		tick <= (tick >= D) ? 0 : tick + 1;
		if (!aresetn) begin
			{full_down, door_closed, door_open, full_up} <= 4'h0;
			{seq_disch_allowed, wash_done, disch_done} <= 3'h0;
			disch_cmd <= 2'h0;
		end else if (tick == D) begin
			if (door_close) begin
				{full_down, door_closed, door_open, full_up} <= 4'hC;
				disch_cmd <= 2'h0;
			end
			wash_done <= wash_run;
			seq_disch_allowed <= seq_disch_desired;
			if (disch_status == DS_WANT_TO_TRANSFER_DEF) begin
				disch_cmd <= DC_GET_READY_DEF;
			end
			if (lu_allowed && disch_commanded && !start_discharging) begin
				{door_closed, door_open} <= 2'h1;
			end
			if (disch_status == DS_READY_TO_RECEIVE_DEF) begin
				disch_cmd <= DC_START_TRANSFER_DEF;
			end
			if (start_discharging && lu_allowed) begin
				{full_down, full_up} <= 2'h1;
			end
			disch_done <= disch_run;
		end
	end
endmodule

// ==== testbench/tb_load_discharge_handshake_fsm.sv ====
`timescale 1ns/100ps
`define CHK(s, e, a) begin comparisons++; if ((a) !== (e)) begin \
	n_fail++; $display("wrong value %s exp %h seen %h", s, e, a); end end
module tb_load_discharge_handshake_fsm;
	import ldhs_pkg::*;
	localparam int TC = 20;
	typedef struct {bit wr; logic [31:0] a; logic [31:0] d; logic [1:0] r;} ldhs_row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, disch_cmd, load_status;
	logic [1:0] disch_status, rd_r;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, full_down, door_closed;
	logic door_open, full_up, seq_disch_allowed, wash_done, disch_done;
	logic door_close, seq_load_done, wash_run, seq_disch_desired;
	logic shuttle_disch_allowed, allied_disch_desired, shuttle_flag_down;
	logic lu_allowed, disch_commanded, start_discharging, disch_run;
	int n_fail = 0, comparisons = 0, cyc = 0, cnt;
	ldhs_row_t rows [11] = '{
		'{0, 32'h0, 32'h0, 2'h0}, '{0, 32'h4, 32'h0, 2'h0},
		'{0, 32'h8, 32'h0, 2'h0}, '{0, 32'hC, 32'h0, 2'h2},
		'{1, 32'hC, 32'h1, 2'h2}, '{1, 32'h4, 32'hFFFF, 2'h0},
		'{0, 32'h4, 32'h0, 2'h0}, '{1, 32'h0, 32'h2, 2'h0},
		'{0, 32'h4, 32'h2000, 2'h0}, '{0, 32'h0, 32'h0, 2'h0},
		'{1, 32'h0, 32'h1, 2'h0}};
	ldhs_fsm #(.TIMER_CYCLES(TC)) uut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .full_down, .door_closed, .door_open,
		.full_up, .seq_disch_allowed, .wash_done, .disch_done, .disch_cmd,
		.door_close, .seq_load_done, .wash_run, .seq_disch_desired,
		.shuttle_disch_allowed, .allied_disch_desired, .shuttle_flag_down,
		.lu_allowed, .disch_commanded, .start_discharging, .disch_run,
		.load_status, .disch_status);
	ldhs_partner #(.D(3)) far (.aclk, .aresetn, .door_close, .wash_run,
		.seq_disch_desired, .lu_allowed, .disch_commanded, .start_discharging,
		.disch_run, .disch_status, .full_down, .door_closed, .door_open,
		.full_up, .seq_disch_allowed, .wash_done, .disch_done, .disch_cmd);
	////////////////////////////////////////////////////////////////////////
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim;
		end
	end
	task end_sim;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Each transfer starts one edge after the last, so no strobe is set twice.
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d, rd_r);
				`CHK("bresp", rows[i].r, rd_r)
			end else begin
				rd(rows[i].a, rd_d, rd_r);
				`CHK("rdata", rows[i].d, rd_d)
				`CHK("rresp", rows[i].r, rd_r)
			end
		end
		wait (door_close === 1'b1) #1;
		`CHK("load_status", LS_CANNOT_RECEIVE_DEF, load_status)
		wait (seq_load_done === 1'b1) #1;
		`CHK("door_close", 1'b0, door_close)
		cnt = 0;
		while (seq_load_done === 1'b1) begin
			@(posedge aclk) #1;
			cnt++;
		end
		`CHK("hold", 1'b1, cnt >= TC)
		`CHK("wash_run", 1'b1, wash_run)
		`CHK("desired", 1'b0, seq_disch_desired)
		wait (shuttle_disch_allowed === 1'b1) #1;
		`CHK("disch_status", DS_WANT_TO_TRANSFER_DEF, disch_status)
		`CHK("allied", 1'b1, allied_disch_desired)
		`CHK("desired", 1'b1, seq_disch_desired)
		wait (shuttle_flag_down === 1'b1) #1;
		`CHK("seq outs", 2'h0, {seq_disch_desired, shuttle_disch_allowed})
		`CHK("door outs", 2'h3, {lu_allowed, disch_commanded})
		wait (disch_status === DS_READY_TO_RECEIVE_DEF) #1;
		`CHK("door outs", 2'h0, {lu_allowed, disch_commanded})
		`CHK("start", 1'b0, start_discharging)
		wait (start_discharging === 1'b1) #1;
		`CHK("door outs", 2'h3, {lu_allowed, disch_commanded})
		`CHK("cmd", DC_START_TRANSFER_DEF, disch_cmd)
		`CHK("disch_run", 1'b0, disch_run)
		wait (disch_run === 1'b1) #1;
		`CHK("load_status", LS_WANT_TO_RECEIVE_DEF, load_status)
		wait (disch_run === 1'b0) #1;
		rd(32'h4, rd_d, rd_r);
		`CHK("state", 4'h0, rd_d[3:0])
		// A reset in mid-wash must drop every output and the enable.
		wr(32'h0, 32'h3, rd_r);
		wait (wash_run === 1'b1);
		@(posedge aclk) aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		`CHK("wash_run", 1'b0, wash_run)
		`CHK("load_status", LS_NONE_DEF, load_status)
		@(posedge aclk) aresetn <= 1'b1;
		rd(32'h0, rd_d, rd_r);
		`CHK("ctrl", 32'h0, rd_d)
		end_sim;
	end
endmodule
